// [verilog/stack_limit_pkg.sv]
// Purpose: Shared constants for the stack pointer and stack limit checker.
// Assumes: 16-bit data words, word-aligned stack accesses.
// Notes: The underflow floor keeps the stack clear of the special register space.
package stack_limit_pkg;
    localparam int unsigned WORD_W = 16;
    localparam logic [15:0] UNDERFLOW_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] SP_RESET_VALUE = 16'h0800;
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    localparam int unsigned MSB_HI = 15;
    localparam int unsigned MSB_LO = 8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    // Operation codes presented by the address generation logic.
    typedef enum logic [3:0] {
        OP_NONE = 4'h1,
        OP_PUSH = 4'h2,
        OP_POP = 4'h4,
        OP_ACCESS = 4'h8
    } stack_op_t;
endpackage : stack_limit_pkg

// [verilog/stack_limit_checker.sv]
// Purpose: Stack pointer upkeep and stack error detection for a 16-bit core.
// Assumes: One core clock; requests come from logic on the same clock.
// Assumes: The address generator presents at most one stack operation per cycle.
// Notes: The limit register holds whatever software last wrote; no reset value.
// Notes: Error outputs are one-cycle pulses, so the exception logic must latch them.
// Overview of operation
// RULE1: Stack pointer always addresses first free word, upward.
// RULE2: Pop predecrements, push postincrements the pointer.
// RULE3: Call push clears program counter upper byte.
// RULE4: Exception push merges status low byte upward.
// RULE5: Limit register left uninitialized at reset.
// RULE6: Limit register bit zero forced to zero.
// RULE7: Stack-pointer effective addresses compared with limit.
// RULE8: Push at limit is fine; next push traps.
// RULE9: Pointer below 0800h raises underflow trap.
// RULE10: Software avoids stack read right after limit write.
// RULE11: Overflow or underflow signalled as stack error event.
// RULE12: Limit register is 16-bit read/write, bit zero zero.
`timescale 1ns/1ps
`default_nettype none
module stack_limit_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Stack operation request
    input wire stack_limit_pkg::stack_op_t op_i,
    input wire logic call_push_i,
    input wire logic exc_push_i,
    input wire logic [15:0] pc_word_i,
    input wire logic [7:0] status_low_byte_i,
    // Direct writes to the pointer and limit
    input wire logic sp_wr_i,
    input wire logic [15:0] sp_wdata_i,
    input wire logic lim_wr_i,
    input wire logic [15:0] lim_wdata_i,
    // Results toward the core
    output logic [15:0] stack_addr_o,
    output logic [15:0] push_data_o,
    output logic [15:0] stack_pointer_reg_o,
    output logic [15:0] stack_limit_reg_o,
    output logic overflow_o,
    output logic underflow_o,
    output logic stack_error_o
);
    import stack_limit_pkg::*;

    logic [15:0] sp_q, sp_d;
    logic [15:0] lim_q, lim_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] pdata_q, pdata_d;
    logic ovf_q, ovf_d, unf_q, unf_d;
    logic [15:0] ea;

    // The effective address is formed once per operation and every check below
    // compares that same value, so push, pop and indirect access cannot disagree.
    // A pointer that wraps past the top of memory compares as a small address and
    // is then caught by the underflow floor rather than by the limit.
    // Next-state logic for pointer, addresses and error flags.
    always_comb begin
        sp_d = sp_q;
        addr_d = addr_q;
        pdata_d = pdata_q;
        ovf_d = 1'b0;
        unf_d = 1'b0;
        ea = sp_q;
        case (op_i)
            OP_PUSH: begin
                ea = sp_q; // RULE1
                sp_d = sp_q + WORD_STEP; // RULE2
                addr_d = ea;
                // A call wins over an exception flag raised in the same cycle,
                // which keeps the upper byte clear even if both are requested.
                if (call_push_i) begin
                    pdata_d = {BYTE_ZERO, pc_word_i[MSB_LO-1:0]}; // RULE3
                end else if (exc_push_i) begin
                    pdata_d = {status_low_byte_i, pc_word_i[MSB_LO-1:0]}; // RULE4
                end else begin
                    pdata_d = pc_word_i;
                end
                // Writing at the limit is allowed; only beyond it traps.
                ovf_d = (ea > lim_q); // RULE7 RULE8
                unf_d = (ea < UNDERFLOW_FLOOR); // RULE9
            end
            OP_POP: begin
                ea = sp_q - WORD_STEP; // RULE2
                sp_d = ea;
                addr_d = ea;
                ovf_d = (ea > lim_q); // RULE7
                unf_d = (ea < UNDERFLOW_FLOOR); // RULE9
            end
            OP_ACCESS: begin
                ea = sp_q;
                addr_d = ea;
                ovf_d = (ea > lim_q); // RULE7
                unf_d = (ea < UNDERFLOW_FLOOR); // RULE9
            end
            OP_NONE: begin
                ea = sp_q;
            end
            default: begin
                ea = sp_q;
            end
        endcase
        // A direct pointer write wins over the operation of the same cycle, so
        // software can reload the pointer without waiting for the stack to settle.
        if (sp_wr_i) begin
            sp_d = sp_wdata_i & ALIGN_MASK;
        end
    end

    // Until software writes the limit every overflow compare is unknown, so boot
    // code must set the limit before the first push.
    always_comb begin
        lim_d = lim_q;
        if (lim_wr_i) begin
            lim_d = lim_wdata_i & ALIGN_MASK; // RULE6 RULE12
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp_q <= SP_RESET_VALUE;
            addr_q <= WORD_ZERO;
            pdata_q <= WORD_ZERO;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            addr_q <= addr_d;
            pdata_q <= pdata_d;
            ovf_q <= ovf_d;
            unf_q <= unf_d;
        end
    end

    // The limit has no reset branch on purpose, so software must set it.
    always_ff @(posedge clk_i) begin
        lim_q <= lim_d; // RULE5
    end

    // All results come from flip-flops, stack_error_o and the limit output through one gate each, so the exception logic sees
    // clean pulses with no glitches from the compare chain.
    assign stack_addr_o = addr_q;
    assign push_data_o = pdata_q;
    assign stack_pointer_reg_o = sp_q;
    assign stack_limit_reg_o = lim_q & ALIGN_MASK; // RULE12
    assign overflow_o = ovf_q;
    assign underflow_o = unf_q;
    assign stack_error_o = ovf_q | unf_q; // RULE11

    // Checks below watch the registered outputs one cycle after each request.
    sequence s_push_past_limit;
        (op_i == OP_PUSH) && !sp_wr_i && (sp_q > lim_q);
    endsequence

    // A push exactly at the limit leaves the pointer one word past it, so the
    // push that follows is the first one that must trap.
    sequence s_push_at_limit;
        (op_i == OP_PUSH) && !sp_wr_i && !lim_wr_i && (sp_q == lim_q);
    endsequence

    a_push_increments: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE2
        (op_i == OP_PUSH) && !sp_wr_i |=> sp_q == $past(sp_q) + WORD_STEP)
        else $error("Push did not advance pointer by one word.");
    a_push_free_word: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
        (op_i == OP_PUSH) |=> stack_addr_o == $past(sp_q))
        else $error("Push did not store at the first free word.");
    a_pop_decrements: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE2
        (op_i == OP_POP) && !sp_wr_i
        |=> (stack_addr_o == sp_q) && (sp_q == $past(sp_q) - WORD_STEP))
        else $error("Pop address is not the predecremented pointer.");
    a_access_addr: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE7
        (op_i == OP_ACCESS) && !sp_wr_i
        |=> (stack_addr_o == sp_q) && (sp_q == $past(sp_q)))
        else $error("Indirect access moved the pointer or used a wrong address.");

    a_call_zero_msb: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        (op_i == OP_PUSH) && call_push_i |=> push_data_o[MSB_HI:MSB_LO] == BYTE_ZERO)
        else $error("Call push left upper byte set.");
    a_call_low_byte: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        (op_i == OP_PUSH) && call_push_i
        |=> push_data_o[MSB_LO-1:0] == $past(pc_word_i[MSB_LO-1:0]))
        else $error("Call push lost the low program counter byte.");
    a_exc_merge_status: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE4
        (op_i == OP_PUSH) && !call_push_i && exc_push_i
        |=> push_data_o[MSB_HI:MSB_LO] == $past(status_low_byte_i))
        else $error("Exception push lost status byte.");

    a_limit_aligned: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
        lim_wr_i |=> stack_limit_reg_o == ($past(lim_wdata_i) & ALIGN_MASK))
        else $error("Limit write not stored with bit zero cleared.");
    a_pointer_aligned: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
        sp_wr_i |=> stack_pointer_reg_o[0] == 1'b0)
        else $error("Pointer write left bit zero set.");
    a_limit_holds: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE12
        lim_wr_i ##1 !lim_wr_i |=> $stable(stack_limit_reg_o))
        else $error("Limit changed without a write.");

    a_at_limit_ok: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE8
        (op_i == OP_PUSH) && (sp_q == lim_q) && (sp_q >= UNDERFLOW_FLOOR)
        |=> !stack_error_o)
        else $error("Push at limit raised an error.");
    a_next_push_traps: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE8
        s_push_at_limit ##1 s_push_past_limit |=> overflow_o)
        else $error("Push after the limit word did not trap.");
    a_past_limit_trap: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE7
        s_push_past_limit |=> overflow_o && stack_error_o)
        else $error("Push past limit did not trap.");
    a_underflow_trap: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE9
        (op_i == OP_POP) && (sp_q - WORD_STEP < UNDERFLOW_FLOOR)
        |=> underflow_o && stack_error_o)
        else $error("Underflow not trapped.");
    a_floor_word_ok: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE9
        (op_i == OP_POP) && (sp_q == UNDERFLOW_FLOOR + WORD_STEP) |=> !underflow_o)
        else $error("Pop to the floor word raised underflow.");

    a_error_source: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
        stack_error_o |-> $past(op_i) != OP_NONE)
        else $error("Error with no stack access.");
    a_error_one_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
        stack_error_o && (op_i == OP_NONE) |=> !stack_error_o)
        else $error("Stack error outlived its access.");
endmodule // stack_limit_checker
`default_nettype wire

// [testbench/core_req_model.sv]
// Purpose: Core-side request source for the stack checker.
// Assumes: Codes 0..3 mean none, push, pop, access.
// Notes: A stack read right after a limit write is turned into no operation and not issued later.
`timescale 1ns/1ps
`default_nettype none
module core_req_model (
    // Bench side
    input wire logic clk_i,
    input wire logic [1:0] code_i,
    input wire logic lim_wr_i,
    // Toward the checker
    output var stack_limit_pkg::stack_op_t op_o
);
    import stack_limit_pkg::*;
    logic lw_q;
    always_ff @(posedge clk_i) lw_q <= lim_wr_i;
    always_comb begin
        case (code_i)
            2'h1: op_o = OP_PUSH;
            2'h2: op_o = lw_q ? OP_NONE : OP_POP;
            2'h3: op_o = lw_q ? OP_NONE : OP_ACCESS;
            default: op_o = OP_NONE;
        endcase
    end
endmodule // core_req_model
`default_nettype wire

// [testbench/test_stack_limit_checker.sv]
// Purpose: Self-checking bench for the stack checker.
// Assumes: One result cycle after each request.
// Notes: Random steps follow directed limit and floor cases.
`timescale 1ns/1ps
`default_nettype none
module test_stack_limit_checker;
    import stack_limit_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, cp = 1'b0, ep = 1'b0, spw = 1'b0, lw = 1'b0;
    logic [1:0] code = 2'h0;
    logic [7:0] slb = 8'h00;
    logic [15:0] pc = 16'h0000, wd = 16'h0000;
    logic [15:0] addr, data, sp, lim, x_addr, x_data, x_sp, x_lim, ea;
    logic ov, un, se, x_ov, x_un;
    stack_op_t op, k;
    int errors = 0, n_checks = 0, cyc = 0, seed;
    always #25 clk_i = ~clk_i;
    core_req_model i_core_req_model (.clk_i(clk_i), .code_i(code), .lim_wr_i(lw), .op_o(op));
    stack_limit_checker i_stack_limit_checker (.clk_i(clk_i), .resetn_i(resetn_i),
        .op_i(op), .call_push_i(cp), .exc_push_i(ep), .pc_word_i(pc),
        .status_low_byte_i(slb), .sp_wr_i(spw), .sp_wdata_i(wd), .lim_wr_i(lw),
        .lim_wdata_i(wd), .stack_addr_o(addr), .push_data_o(data),
        .stack_pointer_reg_o(sp), .stack_limit_reg_o(lim), .overflow_o(ov),
        .underflow_o(un), .stack_error_o(se));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic step(input logic [1:0] c, input logic [1:0] w, input logic [15:0] d);
        {code, spw, lw, wd} = {c, w == 2'h1, w == 2'h2, d};
        {cp, ep} = 2'($urandom);
        {slb, pc} = 24'($urandom);
        #1 k = op;
        ea = (k == OP_POP) ? x_sp - WORD_STEP : x_sp;
        x_ov = (k != OP_NONE) && ea > x_lim;
        x_un = (k != OP_NONE) && ea < UNDERFLOW_FLOOR;
        if (k != OP_NONE) x_addr = ea;
        if (k == OP_PUSH) x_data = cp ? {BYTE_ZERO, pc[7:0]} : ep ? {slb, pc[7:0]} : pc;
        if (k == OP_PUSH) x_sp = x_sp + WORD_STEP;
        if (k == OP_POP) x_sp = ea;
        if (spw) x_sp = wd & ALIGN_MASK;
        if (lw) x_lim = wd & ALIGN_MASK;
        @(posedge clk_i);
        #1 chk(sp, x_sp);
        chk(addr, x_addr);
        chk(data, x_data);
        chk(lim, x_lim);
        chk(ov, x_ov);
        chk(un, x_un);
        chk(se, x_ov | x_un);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 2000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        seed = $urandom(32'hC7DEF3EF);
        {x_sp, x_addr, x_data} = {SP_RESET_VALUE, WORD_ZERO, WORD_ZERO};
        x_lim = 16'hxxxx & ALIGN_MASK;
        repeat (3) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        step(2'h0, 2'h0, 16'h0000);
        step(2'h0, 2'h2, 16'h0DF5);
        step(2'h0, 2'h1, 16'h0DF2);
        repeat (3) step(2'h1, 2'h0, 16'h0000);
        step(2'h0, 2'h1, 16'h0803);
        repeat (2) step(2'h2, 2'h0, 16'h0000);
        $display("directed cases done");
        // A second reset must return the pointer to 0800h but keep the limit that software wrote.
        resetn_i = 1'b0;
        @(posedge clk_i);
        #1 resetn_i = 1'b1;
        {x_sp, x_addr, x_data} = {SP_RESET_VALUE, WORD_ZERO, WORD_ZERO};
        chk(sp, x_sp);
        chk(addr, x_addr);
        chk(lim, x_lim);
        chk(se, 1'b0);
        $display("reset cases done");
        repeat (400) step(2'($urandom), 2'($urandom % 3), 16'h0800 + 16'($urandom & 16'h07FF));
        $display("random cases done");
        report_and_stop();
    end
endmodule // test_stack_limit_checker
`default_nettype wire
